/* File: ppm_pkg.sv */
// Package for the profile-position sequencer: offsets, control bits, status bits, timing
package ppm_pkg;

	// ****************************************************************
	// Object offsets and bit positions
	// ****************************************************************
	localparam logic [15:0] PPM_CTRL_OFS       = 16'h6040;
	localparam logic [15:0] PPM_STAT_OFS       = 16'h6041;
	localparam logic [7:0]  PPM_MODE_PROFILE   = 8'h01;
	localparam int          PPM_CW_NEW_SP      = 4;
	localparam int          PPM_CW_IMMEDIATE   = 5;
	localparam int          PPM_CW_RELATIVE    = 6;
	localparam int          PPM_CW_HALT        = 8;
	localparam int          PPM_CW_CHANGE_SP   = 9;
	localparam int          PPM_SW_REACHED     = 10;
	localparam int          PPM_SW_LIMIT       = 11;
	localparam int          PPM_SW_ACK         = 12;
	localparam int          PPM_SW_FOLLOW      = 13;
	localparam logic [15:0] PPM_CTRL_RESET     = 16'h0000;
	localparam logic [15:0] PPM_STAT_RESET     = 16'h0000;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          PPM_CLK_MHZ        = 200;
	localparam int          PPM_CYCLE_US       = 1000;
	localparam int          PPM_CYCLE_CLKS     = PPM_CYCLE_US * PPM_CLK_MHZ;
	localparam logic [31:0] PPM_POS_RESET      = 32'h0000_0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic signed [31:0] target;
		logic        [31:0] velocity;
		logic        [31:0] accel;
		logic        [31:0] decel;
		logic               relative;
	} ppm_cmd_t;

	typedef struct packed {
		logic [1:0] rel_ref;   // Relative reference select
		logic [1:0] auto_clr;  // Self-clear of new set-point bit
	} ppm_opt_t;

	typedef enum logic [1:0] {
		PPM_IDLE,
		PPM_MOVE,
		PPM_HALTED,
		PPM_SETTLE
	} ppm_state_t;

endpackage : ppm_pkg

/* File: ppm_tick.sv */
// Application-cycle tick generator for the profile-position sequencer
module ppm_tick
	import ppm_pkg::*;
#(
	parameter int CYCLE_CLKS = PPM_CYCLE_CLKS
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	output      logic tick
);

	localparam int CW = $clog2(CYCLE_CLKS);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// ****************************************************************
	// Divider
	// ****************************************************************

	// Free-running count; one pulse per application cycle
	always_comb begin
		tick  = (cnt_q == CW'(CYCLE_CLKS - 1));
		cnt_d = tick ? '0 : cnt_q + CW'(1);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

endmodule : ppm_tick

/* File: ppm_seq.sv */
// Profile-position sequencer: control word, status word, pending-target slot and move tracker
module ppm_seq
	import ppm_pkg::*;
#(
	parameter int CYCLE_CLKS = PPM_CYCLE_CLKS
)
(
	input  wire logic               MCLK,
	input  wire logic               RESETN,
	input  wire logic               CE,
	input  wire logic               CTRL_WE,
	input  wire logic [15:0]        CTRL_WDATA,
	output      logic [15:0]        CTRL_RDATA,
	output      logic [15:0]        STATUS,
	input  wire logic [7:0]         OPERATING_MODE_SELECT,
	input  wire ppm_cmd_t           NEW_CMD,
	input  wire ppm_opt_t           POS_OPTION,
	input  wire logic signed [31:0] LIMIT_MIN,
	input  wire logic signed [31:0] LIMIT_MAX,
	input  wire logic [31:0]        END_VELOCITY,
	input  wire logic [31:0]        WINDOW,
	input  wire logic [15:0]        WINDOW_TIME,
	input  wire logic [31:0]        FOLLOW_WINDOW,
	input  wire logic [15:0]        FOLLOW_TIMEOUT,
	input  wire logic               CLOSED_LOOP,
	input  wire logic               RAMP_REACHABLE,
	input  wire logic signed [31:0] ACTUAL_POS,
	input  wire logic signed [31:0] DEMAND_POS,
	input  wire logic               MOTION_DONE,
	output      ppm_cmd_t           ACTIVE_CMD,
	output      logic [31:0]        FINAL_VELOCITY,
	output      logic               HALT_REQ,
	output      logic               MOVE_START
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic               tick;
	logic [15:0]        ctrl_q,    ctrl_d;
	logic [15:0]        stat_q,    stat_d;
	logic               nsp_q,     nsp_d;
	logic               mode_q,    mode_d;
	ppm_state_t         st_q,      st_d;
	ppm_cmd_t           act_q,     act_d;
	ppm_cmd_t           pend_q,    pend_d;
	logic               pend_v_q,  pend_v_d;
	logic               pass_q,    pass_d;
	logic signed [31:0] base_q,    base_d;
	logic signed [31:0] samp_q,    samp_d;
	logic [15:0]        win_cnt_q, win_cnt_d;
	logic [15:0]        fe_cnt_q,  fe_cnt_d;
	logic [31:0]        fvel_q,    fvel_d;
	logic               start_q,   start_d;

	// ****************************************************************
	// Cycle tick
	// ****************************************************************
	// Default is the 1 ms cycle; a shorter count only serves quick simulation
	ppm_tick #(.CYCLE_CLKS(CYCLE_CLKS)) u_tick (
		.clk   (MCLK),
		.rst_n (RESETN),
		.ce    (CE),
		.tick  (tick)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Absolute difference, used for both tolerance windows
	function automatic logic [31:0] ppm_absdiff(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [31:0] d;
		d = a - b;
		return d[31] ? 32'(-d) : 32'(d);
	endfunction : ppm_absdiff

	// ****************************************************************
	// Sequencer
	// ****************************************************************

	// All decisions run on the cycle tick so sub-cycle glitches vanish
	always_comb begin
		logic               in_mode;
		logic               trig;
		logic               accept;
		logic signed [31:0] tgt;
		logic signed [31:0] ref_pos;
		logic               outside;
		logic               heads_in;
		ppm_cmd_t           cmd;
		in_mode   = 1'b0;
		trig      = 1'b0;
		accept    = 1'b0;
		tgt       = '0;
		ref_pos   = '0;
		outside   = 1'b0;
		heads_in  = 1'b0;
		cmd       = NEW_CMD;
		ctrl_d    = CTRL_WE ? CTRL_WDATA : ctrl_q;
		stat_d    = stat_q;
		nsp_d     = nsp_q;
		mode_d    = mode_q;
		st_d      = st_q;
		act_d     = act_q;
		pend_d    = pend_q;
		pend_v_d  = pend_v_q;
		pass_d    = pass_q;
		base_d    = base_q;
		samp_d    = samp_q;
		win_cnt_d = win_cnt_q;
		fe_cnt_d  = fe_cnt_q;
		fvel_d    = fvel_q;
		start_d   = 1'b0;
		if (tick) begin
			in_mode = (OPERATING_MODE_SELECT == PPM_MODE_PROFILE);
			mode_d  = in_mode;
			samp_d  = ACTUAL_POS;
			// Edge on bit 4, or level when just entering the mode
			trig    = in_mode && ctrl_q[PPM_CW_NEW_SP] &&
				(!nsp_q || !mode_q);
			nsp_d   = ctrl_q[PPM_CW_NEW_SP];
			// Relative reference: last target, or actual sample
			ref_pos = (POS_OPTION.rel_ref == 2'b00) ? base_q : samp_q;
			// Control bit 6 picks relative; the command's own flag is not used
			tgt     = ctrl_q[PPM_CW_RELATIVE] ? ref_pos + NEW_CMD.target : NEW_CMD.target;
			outside = (samp_q < LIMIT_MIN) || (samp_q > LIMIT_MAX);
			heads_in = (samp_q < LIMIT_MIN) ? (tgt > samp_q) : (tgt < samp_q);
			// Clamp to software limits
			if (tgt < LIMIT_MIN) begin
				tgt = LIMIT_MIN;
			end else if (tgt > LIMIT_MAX) begin
				tgt = LIMIT_MAX;
			end
			cmd.target   = tgt;
			cmd.relative = 1'b0;
			// Refuse when acknowledge still set, slot full without the immediate bit, or unreachable
			accept = trig && !stat_q[PPM_SW_ACK] && (!outside || heads_in) &&
				(ctrl_q[PPM_CW_IMMEDIATE] || st_q == PPM_IDLE || !pend_v_q);
			if (accept) begin
				stat_d[PPM_SW_ACK]     = 1'b1;
				stat_d[PPM_SW_REACHED] = 1'b0;
				if (ctrl_q[PPM_CW_IMMEDIATE] || st_q == PPM_IDLE) begin
					act_d    = cmd;
					pend_v_d = 1'b0;
					base_d   = tgt;
					st_d     = ctrl_q[PPM_CW_HALT] ? PPM_HALTED : PPM_MOVE;
					start_d  = 1'b1;
				end else begin
					pend_d   = cmd;
					pend_v_d = 1'b1;
					base_d   = tgt;
				end
				// Self-clear of the new set-point bit
				if (POS_OPTION.auto_clr != 2'b00) begin
					ctrl_d[PPM_CW_NEW_SP] = 1'b0;
				end
			end else if (!ctrl_q[PPM_CW_NEW_SP]) begin
				// Acknowledge follows the request bit; it drops once bit 4 reads low, whether or not the slot is free
				stat_d[PPM_SW_ACK] = 1'b0;
			end
			// Pass-through only when ramp speed reachable at target
			pass_d = ctrl_q[PPM_CW_CHANGE_SP] && !ctrl_q[PPM_CW_IMMEDIATE] &&
				RAMP_REACHABLE;
			// No braking before a pending target when passing through
			fvel_d = (pend_v_q && pass_d) ? act_q.velocity :
				(pend_v_q ? END_VELOCITY : 32'h0000_0000);
			// A direct start owns the state this tick, so the old state's exits are skipped
			unique case (start_d ? PPM_IDLE : st_q)
				PPM_IDLE: begin
				end
				PPM_MOVE: begin
					if (ctrl_q[PPM_CW_HALT]) begin
						st_d = PPM_HALTED;
					end else if (MOTION_DONE) begin
						// A target queued on this very tick is promoted too, never stranded
						if (pend_v_d) begin
							act_d    = pend_d;
							pend_v_d = 1'b0;
							start_d  = 1'b1;
						end else begin
							st_d      = PPM_SETTLE;
							win_cnt_d = '0;
						end
					end
				end
				PPM_HALTED: begin
					if (!ctrl_q[PPM_CW_HALT]) begin
						st_d    = PPM_MOVE;
						start_d = 1'b1;
					end
				end
				PPM_SETTLE: begin
					// Window time counted in application cycles
					if (pend_v_d) begin
						// A target queued while settling starts at once
						act_d    = pend_d;
						pend_v_d = 1'b0;
						st_d     = PPM_MOVE;
						start_d  = 1'b1;
					end else if (ppm_absdiff(samp_q, act_q.target) > WINDOW) begin
						win_cnt_d = '0;
					end else if (win_cnt_q >= WINDOW_TIME) begin
						stat_d[PPM_SW_REACHED] = 1'b1;
						st_d = PPM_IDLE;
					end else begin
						win_cnt_d = win_cnt_q + 16'h0001;
					end
				end
			endcase
			// Demand beyond software limits
			stat_d[PPM_SW_LIMIT] = (DEMAND_POS < LIMIT_MIN) || (DEMAND_POS > LIMIT_MAX);
			// Following error needs the window exceeded past the timeout
			if (CLOSED_LOOP && ppm_absdiff(ACTUAL_POS, DEMAND_POS) > FOLLOW_WINDOW) begin
				if (fe_cnt_q >= FOLLOW_TIMEOUT) begin
					stat_d[PPM_SW_FOLLOW] = 1'b1;
				end else begin
					fe_cnt_d = fe_cnt_q + 16'h0001;
				end
			end else begin
				fe_cnt_d = '0;
				stat_d[PPM_SW_FOLLOW] = 1'b0;
			end
		end
	end

	// Register everything; clock enable freezes the whole sequencer
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_q    <= PPM_CTRL_RESET;
			stat_q    <= PPM_STAT_RESET;
			nsp_q     <= 1'b0;
			mode_q    <= 1'b0;
			st_q      <= PPM_IDLE;
			act_q     <= '0;
			pend_q    <= '0;
			pend_v_q  <= 1'b0;
			pass_q    <= 1'b0;
			base_q    <= PPM_POS_RESET;
			samp_q    <= PPM_POS_RESET;
			win_cnt_q <= '0;
			fe_cnt_q  <= '0;
			fvel_q    <= '0;
			start_q   <= 1'b0;
		end else if (CE) begin
			ctrl_q    <= ctrl_d;
			stat_q    <= stat_d;
			nsp_q     <= nsp_d;
			mode_q    <= mode_d;
			st_q      <= st_d;
			act_q     <= act_d;
			pend_q    <= pend_d;
			pend_v_q  <= pend_v_d;
			pass_q    <= pass_d;
			base_q    <= base_d;
			samp_q    <= samp_d;
			win_cnt_q <= win_cnt_d;
			fe_cnt_q  <= fe_cnt_d;
			fvel_q    <= fvel_d;
			start_q   <= start_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign CTRL_RDATA     = ctrl_q;
	assign STATUS         = stat_q;
	assign ACTIVE_CMD     = act_q;
	assign FINAL_VELOCITY = fvel_q;
	assign HALT_REQ       = (st_q == PPM_HALTED);
	assign MOVE_START     = start_q;

endmodule : ppm_seq

/* File: ppm_seq_properties.sv */
// Checker of the sequencer's port behaviour
module ppm_seq_properties
	import ppm_pkg::*;
(
	input wire logic               MCLK,
	input wire logic               RESETN,
	input wire logic [15:0]        CTRL_RDATA,
	input wire logic [15:0]        STATUS,
	input wire logic               CLOSED_LOOP,
	input wire logic signed [31:0] LIMIT_MIN,
	input wire logic signed [31:0] LIMIT_MAX,
	input wire logic signed [31:0] DEMAND_POS,
	input wire logic               HALT_REQ,
	input wire logic               MOVE_START
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Properties
	// ********
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);

	// A start shows target-reached cleared, then goes quiet; a queued or resumed start
	// may come after the ack has dropped, so the ack is checked where it rises
	sequence s_start;
		MOVE_START && !STATUS[PPM_SW_REACHED];
	endsequence
	sequence s_quiet;
		!MOVE_START [*8];
	endsequence

	start_pulse_a: assert property (MOVE_START |-> s_start ##1 s_quiet)
		else $error("start pulse malformed");
	ack_cause_a: assert property ($rose(STATUS[PPM_SW_ACK]) |-> $past(CTRL_RDATA[PPM_CW_NEW_SP]))
		else $error("ack without request");
	ack_drop_a: assert property ($fell(STATUS[PPM_SW_ACK]) |-> !$past(CTRL_RDATA[PPM_CW_NEW_SP]))
		else $error("ack dropped with request high");
	status_tick_a: assert property ($changed(STATUS) |=> $stable(STATUS) [*8])
		else $error("status changed between ticks");
	spare_zero_a: assert property ((STATUS & 16'hc3ff) == 16'h0000)
		else $error("unused status bit set");
	limit_cause_a: assert property ($rose(STATUS[PPM_SW_LIMIT]) |->
		$past(DEMAND_POS) > $past(LIMIT_MAX) || $past(DEMAND_POS) < $past(LIMIT_MIN))
		else $error("limit flag inside limits");
	follow_cause_a: assert property ($rose(STATUS[PPM_SW_FOLLOW]) |-> $past(CLOSED_LOOP))
		else $error("following error in open loop");
	halt_cause_a: assert property ($rose(HALT_REQ) |-> $past(CTRL_RDATA[PPM_CW_HALT]))
		else $error("halt without halt bit");
	ack_reached_a: assert property ($rose(STATUS[PPM_SW_ACK]) |-> !STATUS[PPM_SW_REACHED])
		else $error("ack with target reached still set");
endmodule : ppm_seq_properties

bind ppm_seq ppm_seq_properties ppm_seq_properties_inst (
	.MCLK(MCLK), .RESETN(RESETN), .CTRL_RDATA(CTRL_RDATA), .STATUS(STATUS),
	.CLOSED_LOOP(CLOSED_LOOP), .LIMIT_MIN(LIMIT_MIN), .LIMIT_MAX(LIMIT_MAX),
	.DEMAND_POS(DEMAND_POS), .HALT_REQ(HALT_REQ), .MOVE_START(MOVE_START)
);

/* File: ppm_ramp_model.sv */
// Stand-in ramp generator answering start pulses with motion feedback
module ppm_ramp_model
	import ppm_pkg::*;
#(
	parameter int MOVE_CLKS = 40
)
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               move_start,
	input  wire ppm_cmd_t           active_cmd,
	output      logic               motion_done,
	output      logic signed [31:0] actual_pos,
	output      logic signed [31:0] demand_pos
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Motion
	// ********
	int cnt_q;

	// Demand jumps at once; arrival waits MOVE_CLKS, so a large value gives a slow axis
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 0;
			motion_done <= 1'b1;
			actual_pos <= '0;
			demand_pos <= '0;
		end else if (move_start) begin
			cnt_q <= MOVE_CLKS;
			motion_done <= 1'b0;
			demand_pos <= active_cmd.target;
		end else if (cnt_q == 1) begin
			cnt_q <= 0;
			motion_done <= 1'b1;
			actual_pos <= active_cmd.target;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
endmodule : ppm_ramp_model

/* File: tb_profile_position_mode.sv */
// Self-checking bench of the profile-position sequencer
module tb_profile_position_mode
	import ppm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Signals
	// ********
	logic               mclk = 1'b0;
	logic               resetn = 1'b0;
	logic               ce = 1'b0;
	logic               ctrl_we = 1'b0;
	logic [15:0]        ctrl_wdata = 16'h0000;
	logic [7:0]         mode = 8'h00;
	ppm_cmd_t           new_cmd = '0;
	ppm_opt_t           pos_option = '0;
	logic signed [31:0] lim_min = 32'shfff0_0000;
	logic signed [31:0] lim_max = 32'sh0010_0000;
	logic [31:0]        window = 32'h0000_0010;
	logic [15:0]        ctrl_rdata, status, cw;
	ppm_cmd_t           active_cmd;
	logic signed [31:0] act_pos, dem_pos, last_tgt, step;
	logic               motion_done, halt_req, move_start;
	logic signed [31:0] exp_q[$];
	int                 num_errors = 0;
	int                 compares = 0;
	logic               closed_loop = 1'b0;
	logic [31:0]        final_vel;
	localparam int      TICK_CLKS = 64; // Short cycle keeps the run brief

	ppm_seq #(.CYCLE_CLKS(TICK_CLKS)) ppm_seq_inst (
		.MCLK(mclk), .RESETN(resetn), .CE(ce), .CTRL_WE(ctrl_we), .CTRL_WDATA(ctrl_wdata),
		.CTRL_RDATA(ctrl_rdata), .STATUS(status), .OPERATING_MODE_SELECT(mode),
		.NEW_CMD(new_cmd), .POS_OPTION(pos_option), .LIMIT_MIN(lim_min), .LIMIT_MAX(lim_max),
		.END_VELOCITY(32'h0000_0000), .WINDOW(window), .WINDOW_TIME(16'h0001),
		.FOLLOW_WINDOW(32'h0000_0100), .FOLLOW_TIMEOUT(16'h0004), .CLOSED_LOOP(closed_loop),
		.RAMP_REACHABLE(1'b1), .ACTUAL_POS(act_pos), .DEMAND_POS(dem_pos),
		.MOTION_DONE(motion_done), .ACTIVE_CMD(active_cmd), .FINAL_VELOCITY(final_vel),
		.HALT_REQ(halt_req), .MOVE_START(move_start)
	);
	ppm_ramp_model ppm_ramp_model_inst (
		.clk(mclk), .rst_n(resetn), .move_start(move_start), .active_cmd(active_cmd),
		.motion_done(motion_done), .actual_pos(act_pos), .demand_pos(dem_pos)
	);

	// ********
	// Tasks
	// ********
	initial begin
		forever #2.5 mclk = ~mclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] expv);
		compares++;
		if (seen !== expv) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task finish_test;
		if (num_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// One write strobe, launched and dropped on falling edges
	task wr(input logic [15:0] val);
		@(negedge mclk);
		ctrl_wdata = val;
		ctrl_we = 1'b1;
		@(negedge mclk);
		ctrl_we = 1'b0;
	endtask : wr

	// Decisions fall only on the cycle tick, every TICK_CLKS clocks here, so wait one full cycle plus the status edge
	task wait_tick;
		repeat (TICK_CLKS + 4) @(negedge mclk);
	endtask : wait_tick

	// Load a command, trigger it, and wait boundedly for the start pulse
	task go(input logic [15:0] ctl, input logic signed [31:0] tgt, input logic rel,
		input logic signed [31:0] expv);
		@(negedge mclk);
		new_cmd.target = tgt;
		new_cmd.velocity = 32'($urandom_range(1, 4096));
		new_cmd.accel = 32'($urandom_range(1, 4096));
		new_cmd.decel = 32'($urandom_range(1, 4096));
		new_cmd.relative = rel;
		exp_q.push_back(expv);
		wr(ctl);
		check(32'(ctrl_rdata), 32'(ctl));
		for (int i = 0; i < 2 * TICK_CLKS && move_start !== 1'b1; i++) @(negedge mclk);
		repeat (2) @(negedge mclk);
	endtask : go

	// Each start pulse takes the oldest expected target off the queue; sampled where settled
	always @(negedge mclk) begin
		if (move_start === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(32'h0000_0001, 32'h0000_0000);
			end else begin
				check(active_cmd.target, exp_q.pop_front());
			end
			check(32'(status[PPM_SW_ACK]), 32'h0000_0001);
		end
	end

	// ********
	// Scenarios
	// ********
	initial begin
		last_tgt = 32'($urandom(32'h5913));
		window = 32'($urandom_range(1, 255));
		repeat (12) @(negedge mclk);
		resetn = 1'b1;
		ce = 1'b1;
		mode = PPM_MODE_PROFILE;
		check(32'(ctrl_rdata), 32'(PPM_CTRL_RESET));
		check(32'(status), 32'(PPM_STAT_RESET));
		// Immediate absolute move, then a held request level across a tick
		last_tgt = 32'($urandom_range(1, 65535));
		cw = 16'h0030;
		go(cw, last_tgt, 1'b0, last_tgt);
		wait_tick();
		check(32'(status[PPM_SW_ACK]), 32'h0000_0001);
		// Dropping the request releases the ack; the axis settles meanwhile
		cw = 16'h0020;
		wr(cw);
		wait_tick();
		check(32'(status[PPM_SW_ACK]), 32'h0000_0000);
		wait_tick();
		check(32'(status[PPM_SW_REACHED]), 32'h0000_0001);
		// Relative move off the last target, queued mode, random pass-through bit
		step = 32'($urandom_range(1, 4096));
		closed_loop = 1'b1;
		cw = {6'h00, 1'($urandom), 9'h050};
		go(cw, step, 1'b1, last_tgt + step);
		// Halt while the demand sits just beyond a lowered upper limit
		@(negedge mclk);
		lim_max = last_tgt + step - 32'sh0000_0001;
		wr(cw | 16'h0100);
		wait_tick();
		check(32'(status[PPM_SW_LIMIT]), 32'h0000_0001);
		check(32'(halt_req), 32'h0000_0001);
		check(32'(exp_q.size()), 32'h0000_0000);
		check(32'(status[PPM_SW_FOLLOW]), 32'h0000_0000);
		check(final_vel, 32'h0000_0000);
		finish_test();
	end

	// Watchdog sized well past the handful of ticks the scenarios need
	initial begin
		#(16 * TICK_CLKS * 5);
		num_errors++;
		finish_test();
	end
endmodule : tb_profile_position_mode
